// [shared/updown_event_counter_pkg.sv]
// constants, register map and state encodings for the up/down event counter bank
package updown_event_counter_pkg;

  // bank shape
  localparam int unsigned NUM_COUNTERS = 8;
  localparam int unsigned MAX_COUNTERS = 8;
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned STAMP_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // per-counter register block: index in paddr[7:5], word in paddr[4:0]
  localparam int unsigned CNT_IDX_LSB = 5;
  localparam int unsigned CNT_IDX_W = 3;
  localparam logic [11:0] CNT_REGION_END = 12'h100;
  localparam logic [4:0] OFF_PRESET = 5'h00;
  localparam logic [4:0] OFF_COMPARE = 5'h04;
  localparam logic [4:0] OFF_COUNT = 5'h08;
  localparam logic [4:0] OFF_FROZEN = 5'h0c;
  localparam logic [4:0] OFF_STAMP = 5'h10;

  // global registers
  localparam logic [11:0] ADDR_ENABLE = 12'h100;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h104;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h108;

  // interrupt status layout: capture events low byte, equal-reached high byte
  localparam int unsigned IRQ_CAPTURE_LSB = 0;
  localparam int unsigned IRQ_EQUAL_LSB = 8;
  localparam int unsigned IRQ_W = 16;

  // reset values
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;

  // non-volatile save stream: word 2n = running count n, 2n+1 = frozen count n
  localparam int unsigned NV_ADDR_W = 4;

  typedef enum logic [2:0] {
    NV_IDLE = 3'b001,
    NV_SAVE = 3'b010,
    NV_DONE = 3'b100
  } nv_state_e;

  // low-to-high transition between two samples
  function automatic logic rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : rise

endpackage : updown_event_counter_pkg

// [testbench/tb_top.sv]
// self-checking bench for the up/down event counter bank
`timescale 1ns/1ps
module tb_top;
  localparam int N = 8;
  logic i_clk, i_rstn, psel, penable, pwrite, pready, pslverr, pf, nvr, nvv, nvd, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ts, nvdata, rd;
  logic [3:0] nva;
  logic [N-1:0] up, dn, inh, sel, rst, cc, ck, hi, eq, lo;
  int mcnt[N], mpre[N], mcmp[N], mfrz[N], bad_count, samples_checked, w, k;

  updown_event_counter #(.NUM_COUNTERS(N)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_up(up), .i_down(dn), .i_inhibit(inh),
    .i_load_preset_select(sel), .i_reset_cmd(rst), .i_capture_clear(cc),
    .i_capture_continue(ck), .i_timestamp(ts), .o_count_above_flag(hi),
    .o_count_equal_flag(eq), .o_count_below_flag(lo), .o_irq(irq), .i_power_fail(pf),
    .i_nv_ready(nvr), .o_nv_valid(nvv), .o_nv_addr(nva), .o_nv_data(nvdata),
    .o_nv_done(nvd));

  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : check

  // apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", 32'h1, {31'h0, pready});
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check($sformatf("rdata %h", a), e, rd);
    check($sformatf("slverr %h", a), {31'h0, ee}, {31'h0, err});
  endtask : rdc

  function automatic logic [11:0] ra(input int n, input logic [4:0] o);
    return 12'(n * 32) | {7'h0, o};
  endfunction : ra

  task automatic cnt(input int n);
    rdc(ra(n, updown_event_counter_pkg::OFF_COUNT), mcnt[n], 1'b0);
  endtask : cnt

  // expected flags from the model, signed compare
  task automatic flg(input int n);
    logic [2:0] e;
    e = (mcnt[n] > mcmp[n]) ? 3'b100 : (mcnt[n] == mcmp[n]) ? 3'b010 : 3'b001;
    if (inh[n] === 1'b1) e = 3'b000;
    check($sformatf("flags %0d", n), {29'h0, e}, {29'h0, hi[n], eq[n], lo[n]});
  endtask : flg

  // two-cycle high pulse on one event input
  task automatic pulse(input int s, input int n);
    @(posedge i_clk);
    case (s)
      0: up[n] <= 1'b1;
      1: dn[n] <= 1'b1;
      2: rst[n] <= 1'b1;
      3: cc[n] <= 1'b1;
      default: ck[n] <= 1'b1;
    endcase
    repeat (2) @(posedge i_clk);
    {up, dn, rst, cc, ck} <= '0;
    repeat (3) @(posedge i_clk);
  endtask : pulse

  // watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    {i_rstn, psel, penable, pwrite, pf, nvr, paddr, pwdata, ts} = '0;
    {up, dn, inh, sel, rst, cc, ck} = '0;
    void'($urandom(92));
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    // reset values, access kinds, refused addresses
    for (int n = 0; n < N; n++) begin
      rdc(ra(n, updown_event_counter_pkg::OFF_PRESET), 32'h0, 1'b0);
      mpre[n] = $urandom();
      mcmp[n] = $urandom();
      apb(1'b1, ra(n, updown_event_counter_pkg::OFF_PRESET), mpre[n]);
      apb(1'b1, ra(n, updown_event_counter_pkg::OFF_COMPARE), mcmp[n]);
      rdc(ra(n, updown_event_counter_pkg::OFF_PRESET), mpre[n], 1'b0);
    end
    rdc(updown_event_counter_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0);
    apb(1'b1, ra(0, updown_event_counter_pkg::OFF_COUNT), 32'h1234);
    cnt(0);
    rdc(12'h014, 32'h0, 1'b1);
    rdc(12'h10c, 32'h0, 1'b1);
    rdc(12'h102, 32'h0, 1'b1);
    $display("register test done");
    // enable loads preset or zero per selector
    @(posedge i_clk);
    sel <= 8'haa;
    apb(1'b1, updown_event_counter_pkg::ADDR_ENABLE, 32'hff);
    repeat (3) @(posedge i_clk);
    for (int n = 0; n < N; n++) begin
      mcnt[n] = sel[n] ? mpre[n] : 0;
      cnt(n);
      flg(n);
    end
    $display("enable test done");
    // rising events only, up and down
    k = $urandom_range(1, 5);
    repeat (k) pulse(0, 0);
    pulse(1, 0);
    mcnt[0] = k - 1;
    cnt(0);
    // selector edges and wrap at both ends
    @(posedge i_clk);
    sel[1] <= 1'b0;
    apb(1'b1, ra(1, updown_event_counter_pkg::OFF_PRESET), 32'h7fffffff);
    cnt(1);
    @(posedge i_clk);
    sel[1] <= 1'b1;
    repeat (2) @(posedge i_clk);
    mcnt[1] = 32'h7fffffff;
    cnt(1);
    pulse(0, 1);
    mcnt[1] = 32'h80000000;
    cnt(1);
    pulse(1, 1);
    mcnt[1] = 32'h7fffffff;
    cnt(1);
    $display("count test done");
    // compare flags below, equal, above, then inhibit
    mcmp[3] = mcnt[3] + 1;
    apb(1'b1, ra(3, updown_event_counter_pkg::OFF_COMPARE), mcmp[3]);
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 3; i++) begin
      flg(3);
      pulse(0, 3);
      mcnt[3]++;
    end
    @(posedge i_clk);
    inh[3] <= 1'b1;
    pulse(0, 3);
    flg(3);
    cnt(3);
    @(posedge i_clk);
    inh[3] <= 1'b0;
    $display("compare test done");
    // captures, reset command and interrupt
    repeat (3) pulse(0, 4);
    @(posedge i_clk);
    ts <= $urandom();
    pulse(4, 4);
    rdc(ra(4, updown_event_counter_pkg::OFF_FROZEN), 32'h3, 1'b0);
    rdc(ra(4, updown_event_counter_pkg::OFF_STAMP), ts, 1'b0);
    pulse(0, 4);
    mcnt[4] = 4;
    cnt(4);
    apb(1'b1, updown_event_counter_pkg::ADDR_IRQ_STATUS, 32'hffff);
    pulse(3, 4);
    mcnt[4] = 0;
    mfrz[4] = 4;
    cnt(4);
    rdc(ra(4, updown_event_counter_pkg::OFF_FROZEN), 32'h4, 1'b0);
    rdc(updown_event_counter_pkg::ADDR_IRQ_STATUS, 32'h10, 1'b0);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, updown_event_counter_pkg::ADDR_IRQ_MASK, 32'h10);
    @(posedge i_clk);
    check("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, updown_event_counter_pkg::ADDR_IRQ_STATUS, 32'h10);
    @(posedge i_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    pulse(0, 5);
    pulse(2, 5);
    cnt(5);
    pulse(2, 0);
    mcnt[0] = 0;
    cnt(0);
    $display("capture test done");
    // power-down save stream with random stalls
    @(posedge i_clk);
    pf <= 1'b1;
    w = 0;
    for (int c = 0; c < 300 && w < 2 * N; c++) begin
      @(posedge i_clk);
      if (nvv === 1'b1 && nvr === 1'b1) begin
        check("nv addr", w, {28'h0, nva});
        check("nv data", (w % 2) ? mfrz[w / 2] : mcnt[w / 2], nvdata);
        w++;
      end
      nvr <= 1'($urandom_range(0, 1));
    end
    repeat (2) @(posedge i_clk);
    check("nv done", 32'h1, {31'h0, nvd});
    pf <= 1'b0;
    $display("save test done");
    complete_run();
  end
endmodule : tb_top

// [testbench/updown_event_counter_checker.sv]
// port-level assertions for the up/down event counter bank
`timescale 1ns/1ps
module updown_event_counter_checker #(
  parameter int unsigned NUM_COUNTERS = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [NUM_COUNTERS-1:0] i_inhibit,
  input wire logic [NUM_COUNTERS-1:0] o_count_above_flag,
  input wire logic [NUM_COUNTERS-1:0] o_count_equal_flag,
  input wire logic [NUM_COUNTERS-1:0] o_count_below_flag,
  input wire logic i_power_fail,
  input wire logic i_nv_ready,
  input wire logic o_nv_valid,
  input wire logic [updown_event_counter_pkg::NV_ADDR_W-1:0] o_nv_addr,
  input wire logic [updown_event_counter_pkg::COUNT_W-1:0] o_nv_data,
  input wire logic o_nv_done
);
  localparam logic [3:0] LAST = 4'(2 * NUM_COUNTERS - 1);
  wire logic [NUM_COUNTERS-1:0] fa = o_count_above_flag;
  wire logic [NUM_COUNTERS-1:0] fe = o_count_equal_flag;
  wire logic [NUM_COUNTERS-1:0] fb = o_count_below_flag;
  // single domain, reset disables all checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // save stream handshake steps
  sequence nv_take;
    o_nv_valid && i_nv_ready;
  endsequence
  sequence nv_wait;
    o_nv_valid && !i_nv_ready;
  endsequence
  AST_PREADY_ZERO_WAIT: assert property (o_pready == (i_psel && i_penable))
    else $error("pready not zero wait");
  AST_SLVERR_IN_ACCESS: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access");
  AST_FLAGS_EXCLUSIVE: assert property (((fa & fe) | (fa & fb) | (fe & fb)) == '0)
    else $error("two compare flags at once");
  AST_INHIBIT_BLOCKS: assert property
    ((i_inhibit & $past(i_inhibit) & $past(i_inhibit, 2) & (fa | fe | fb)) == '0)
    else $error("flag while inhibited");
  AST_NV_START: assert property
    ($rose(i_power_fail) && !o_nv_valid && !o_nv_done |=> o_nv_valid && o_nv_addr == 4'h0)
    else $error("save stream did not start");
  AST_NV_HOLD: assert property
    (nv_wait |=> o_nv_valid && $stable(o_nv_addr) && $stable(o_nv_data))
    else $error("save word changed while stalled");
  AST_NV_STEP: assert property
    (nv_take ##0 (o_nv_addr != LAST) |=> o_nv_valid && o_nv_addr == $past(o_nv_addr) + 4'h1)
    else $error("save word index not stepped");
  AST_NV_LAST: assert property (nv_take ##0 (o_nv_addr == LAST) |=> !o_nv_valid && o_nv_done)
    else $error("save stream did not finish");
  AST_NV_DONE_HOLD: assert property (o_nv_done && i_power_fail |=> o_nv_done && !o_nv_valid)
    else $error("done dropped while power fail");
endmodule : updown_event_counter_checker

bind updown_event_counter updown_event_counter_checker #(.NUM_COUNTERS(NUM_COUNTERS)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_inhibit(i_inhibit),
  .o_count_above_flag(o_count_above_flag), .o_count_equal_flag(o_count_equal_flag),
  .o_count_below_flag(o_count_below_flag), .i_power_fail(i_power_fail),
  .i_nv_ready(i_nv_ready), .o_nv_valid(o_nv_valid), .o_nv_addr(o_nv_addr),
  .o_nv_data(o_nv_data), .o_nv_done(o_nv_done));

// [verilog/updown_event_counter.sv]
// bank of signed up/down event counters with compare flags, capture and apb access
`timescale 1ns/1ps
module updown_event_counter #(
  parameter int unsigned NUM_COUNTERS = updown_event_counter_pkg::NUM_COUNTERS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [updown_event_counter_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [updown_event_counter_pkg::DATA_W-1:0] i_pwdata,
  output logic [updown_event_counter_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // event inputs, one bit per counter, and the shared capture time stamp
  input wire logic [NUM_COUNTERS-1:0] i_up,
  input wire logic [NUM_COUNTERS-1:0] i_down,
  input wire logic [NUM_COUNTERS-1:0] i_inhibit,
  input wire logic [NUM_COUNTERS-1:0] i_load_preset_select,
  input wire logic [NUM_COUNTERS-1:0] i_reset_cmd,
  input wire logic [NUM_COUNTERS-1:0] i_capture_clear,
  input wire logic [NUM_COUNTERS-1:0] i_capture_continue,
  input wire logic [updown_event_counter_pkg::STAMP_W-1:0] i_timestamp,
  // compare flags
  output logic [NUM_COUNTERS-1:0] o_count_above_flag,
  output logic [NUM_COUNTERS-1:0] o_count_equal_flag,
  output logic [NUM_COUNTERS-1:0] o_count_below_flag,
  // interrupt
  output logic o_irq,
  // non-volatile save stream
  input wire logic i_power_fail,
  input wire logic i_nv_ready,
  output logic o_nv_valid,
  output logic [updown_event_counter_pkg::NV_ADDR_W-1:0] o_nv_addr,
  output logic [updown_event_counter_pkg::COUNT_W-1:0] o_nv_data,
  output logic o_nv_done
);

  localparam int unsigned CW = updown_event_counter_pkg::COUNT_W;
  localparam int unsigned SW = updown_event_counter_pkg::STAMP_W;
  localparam int unsigned AW = updown_event_counter_pkg::ADDR_W;
  localparam int unsigned DW = updown_event_counter_pkg::DATA_W;
  localparam int unsigned IW = updown_event_counter_pkg::IRQ_W;
  localparam int unsigned NAW = updown_event_counter_pkg::NV_ADDR_W;
  localparam int unsigned XW = updown_event_counter_pkg::CNT_IDX_W;
  localparam logic [NAW-1:0] NV_LAST = NAW'(2 * NUM_COUNTERS - 1);

  // elaboration check: address map and irq lanes hold at most eight
  if (NUM_COUNTERS < 1 || NUM_COUNTERS > updown_event_counter_pkg::MAX_COUNTERS) begin : g_bad
    $error("NUM_COUNTERS must lie between 1 and 8");
  end

  // per-counter state, 32-bit two's complement
  logic [NUM_COUNTERS-1:0][CW-1:0] preset_reg;
  logic [NUM_COUNTERS-1:0][CW-1:0] compare_reg;
  logic [NUM_COUNTERS-1:0][CW-1:0] count_reg;
  logic [NUM_COUNTERS-1:0][CW-1:0] frozen_reg;
  logic [NUM_COUNTERS-1:0][SW-1:0] stamp_reg;
  logic [NUM_COUNTERS-1:0] enable_reg;
  logic [IW-1:0] irq_status_reg;
  logic [IW-1:0] irq_mask_reg;
  logic [NUM_COUNTERS-1:0] capture_evt;
  logic [NUM_COUNTERS-1:0] equal_evt;

  // apb decode
  logic setup_phase;
  logic wr_stb;
  logic [DW-1:0] rdata_next;
  logic rerr_next;
  logic [DW-1:0] rdata_reg;
  logic err_reg;

  // decoded address: counter index, word offset and hit
  function automatic logic in_counter(input logic [AW-1:0] a);
    return (a < updown_event_counter_pkg::CNT_REGION_END) &&
           (32'(a[AW-1:updown_event_counter_pkg::CNT_IDX_LSB]) < NUM_COUNTERS);
  endfunction : in_counter

  function automatic logic [XW-1:0] cnt_index(input logic [AW-1:0] a);
    return a[updown_event_counter_pkg::CNT_IDX_LSB +: XW];
  endfunction : cnt_index

  function automatic logic [4:0] cnt_offset(input logic [AW-1:0] a);
    return a[4:0];
  endfunction : cnt_offset

  assign setup_phase = i_psel & ~i_penable;
  assign wr_stb = i_psel & i_penable & i_pwrite;

  // read mux and error decode, evaluated in the setup cycle
  always_comb begin
    rdata_next = '0;
    rerr_next = 1'b0;
    if (i_paddr[1:0] != 2'b00) begin
      rerr_next = 1'b1;
    end else if (in_counter(i_paddr)) begin
      unique case (cnt_offset(i_paddr))
        updown_event_counter_pkg::OFF_PRESET: rdata_next = preset_reg[cnt_index(i_paddr)];
        updown_event_counter_pkg::OFF_COMPARE: rdata_next = compare_reg[cnt_index(i_paddr)];
        updown_event_counter_pkg::OFF_COUNT: rdata_next = count_reg[cnt_index(i_paddr)];
        updown_event_counter_pkg::OFF_FROZEN: rdata_next = frozen_reg[cnt_index(i_paddr)];
        updown_event_counter_pkg::OFF_STAMP: rdata_next = DW'(stamp_reg[cnt_index(i_paddr)]);
        default: rerr_next = 1'b1;
      endcase
    end else if (i_paddr == updown_event_counter_pkg::ADDR_ENABLE) begin
      rdata_next = DW'(enable_reg);
    end else if (i_paddr == updown_event_counter_pkg::ADDR_IRQ_STATUS) begin
      rdata_next = DW'(irq_status_reg);
    end else if (i_paddr == updown_event_counter_pkg::ADDR_IRQ_MASK) begin
      rdata_next = DW'(irq_mask_reg);
    end else begin
      rerr_next = 1'b1;
    end
  end

  // read data and error captured in setup, shown in the access cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (setup_phase) begin
      rdata_reg <= i_pwrite ? '0 : rdata_next;
      err_reg <= rerr_next;
    end
  end

  // zero-wait access phase
  assign o_pready = i_psel & i_penable;
  assign o_pslverr = i_psel & i_penable & err_reg;
  assign o_prdata = rdata_reg;

  // enable and mask registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      enable_reg <= NUM_COUNTERS'(updown_event_counter_pkg::ENABLE_RST);
      irq_mask_reg <= updown_event_counter_pkg::IRQ_MASK_RST;
    end else if (wr_stb && !err_reg) begin
      if (i_paddr == updown_event_counter_pkg::ADDR_ENABLE) begin
        enable_reg <= i_pwdata[NUM_COUNTERS-1:0];
      end
      if (i_paddr == updown_event_counter_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= i_pwdata[IW-1:0];
      end
    end
  end

  // sticky status, write one to clear, a new event beats the clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg &
                         ~((wr_stb && !err_reg &&
                            i_paddr == updown_event_counter_pkg::ADDR_IRQ_STATUS) ?
                           i_pwdata[IW-1:0] : '0)) |
                        (IW'(capture_evt) << updown_event_counter_pkg::IRQ_CAPTURE_LSB) |
                        (IW'(equal_evt) << updown_event_counter_pkg::IRQ_EQUAL_LSB);
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // one identical slice per counter
  for (genvar g = 0; g < NUM_COUNTERS; g++) begin : g_cnt
    logic up_prev;
    logic down_prev;
    logic lps_prev;
    logic rst_prev;
    logic cclr_prev;
    logic ccont_prev;
    logic en_prev;
    logic eq_prev;
    logic up_evt;
    logic down_evt;
    logic lps_evt;
    logic reload_evt;
    logic cclr_evt;
    logic ccont_evt;
    logic en_evt;
    logic lps_now;
    logic [CW-1:0] reload_val;

    // previous samples for edge detection
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        up_prev <= 1'b0;
        down_prev <= 1'b0;
        lps_prev <= 1'b0;
        rst_prev <= 1'b0;
        cclr_prev <= 1'b0;
        ccont_prev <= 1'b0;
        en_prev <= 1'b0;
        eq_prev <= 1'b0;
      end else begin
        up_prev <= i_up[g];
        down_prev <= i_down[g];
        lps_prev <= i_load_preset_select[g];
        rst_prev <= i_reset_cmd[g];
        cclr_prev <= i_capture_clear[g];
        ccont_prev <= i_capture_continue[g];
        en_prev <= enable_reg[g];
        eq_prev <= o_count_equal_flag[g];
      end
    end

    // rising transitions only; falls are ignored, and the preset selector level also picks the reload value
    assign up_evt = updown_event_counter_pkg::rise(up_prev, i_up[g]);
    assign down_evt = updown_event_counter_pkg::rise(down_prev, i_down[g]);
    assign lps_now = i_load_preset_select[g];
    assign lps_evt = updown_event_counter_pkg::rise(lps_prev, lps_now);
    assign cclr_evt = updown_event_counter_pkg::rise(cclr_prev, i_capture_clear[g]);
    assign ccont_evt = updown_event_counter_pkg::rise(ccont_prev, i_capture_continue[g]);
    assign reload_evt = updown_event_counter_pkg::rise(rst_prev, i_reset_cmd[g]) | cclr_evt;
    assign en_evt = updown_event_counter_pkg::rise(en_prev, enable_reg[g]);
    assign reload_val = lps_now ? preset_reg[g] : updown_event_counter_pkg::COUNT_RST;
    assign capture_evt[g] = enable_reg[g] & (cclr_evt | ccont_evt);
    assign equal_evt[g] = ~eq_prev & o_count_equal_flag[g];

    // preset and compare written over apb
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        preset_reg[g] <= updown_event_counter_pkg::PRESET_RST;
        compare_reg[g] <= updown_event_counter_pkg::COMPARE_RST;
      end else if (wr_stb && !err_reg && in_counter(i_paddr) &&
                   32'(cnt_index(i_paddr)) == g) begin
        if (cnt_offset(i_paddr) == updown_event_counter_pkg::OFF_PRESET) begin
          preset_reg[g] <= i_pwdata;
        end
        if (cnt_offset(i_paddr) == updown_event_counter_pkg::OFF_COMPARE) begin
          compare_reg[g] <= i_pwdata;
        end
      end
    end

    // running count: enable load, reload commands, preset edge, then counting
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        count_reg[g] <= updown_event_counter_pkg::COUNT_RST;
      end else if (enable_reg[g]) begin
        if (en_evt) begin
          count_reg[g] <= reload_val;
        end else if (reload_evt) begin
          count_reg[g] <= reload_val;
        end else if (lps_evt) begin
          count_reg[g] <= preset_reg[g];
        end else if (!i_inhibit[g]) begin
          if (up_evt && !down_evt) begin
            count_reg[g] <= count_reg[g] + 32'h0000_0001;
          end else if (down_evt && !up_evt) begin
            count_reg[g] <= count_reg[g] - 32'h0000_0001;
          end
        end
      end
    end

    // frozen copy and time stamp of the pre-command count
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        frozen_reg[g] <= updown_event_counter_pkg::COUNT_RST;
        stamp_reg[g] <= '0;
      end else if (capture_evt[g]) begin
        frozen_reg[g] <= count_reg[g];
        stamp_reg[g] <= i_timestamp;
      end
    end

    // signed compare, flags blocked while inhibited or disabled
    always_ff @(posedge i_clk) begin
      if (!i_rstn || !enable_reg[g] || i_inhibit[g]) begin
        o_count_above_flag[g] <= 1'b0;
        o_count_equal_flag[g] <= 1'b0;
        o_count_below_flag[g] <= 1'b0;
      end else begin
        o_count_above_flag[g] <= $signed(count_reg[g]) > $signed(compare_reg[g]);
        o_count_equal_flag[g] <= count_reg[g] == compare_reg[g];
        o_count_below_flag[g] <= $signed(count_reg[g]) < $signed(compare_reg[g]);
      end
    end
  end

  // power-down save: streams running and frozen counts to storage
  updown_event_counter_pkg::nv_state_e nv_state_reg;
  logic pf_prev;
  logic [NAW-1:0] nv_idx_reg;

  // word n of the save stream
  function automatic logic [CW-1:0] nv_word(input logic [NAW-1:0] idx,
                                            input logic [NUM_COUNTERS-1:0][CW-1:0] run,
                                            input logic [NUM_COUNTERS-1:0][CW-1:0] frz);
    logic [NAW-1:0] sel;
    sel = idx >> 1;
    return idx[0] ? frz[sel] : run[sel];
  endfunction : nv_word

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pf_prev <= 1'b0;
    end else begin
      pf_prev <= i_power_fail;
    end
  end

  // save sequencer, stalled by storage ready
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      nv_state_reg <= updown_event_counter_pkg::NV_IDLE;
      nv_idx_reg <= '0;
      o_nv_data <= '0;
    end else begin
      unique case (nv_state_reg)
        updown_event_counter_pkg::NV_IDLE: begin
          if (updown_event_counter_pkg::rise(pf_prev, i_power_fail)) begin
            nv_state_reg <= updown_event_counter_pkg::NV_SAVE;
            nv_idx_reg <= '0;
            o_nv_data <= nv_word('0, count_reg, frozen_reg);
          end
        end
        updown_event_counter_pkg::NV_SAVE: begin
          if (i_nv_ready) begin
            if (nv_idx_reg == NV_LAST) begin
              nv_state_reg <= updown_event_counter_pkg::NV_DONE;
            end else begin
              nv_idx_reg <= nv_idx_reg + 1'b1;
              o_nv_data <= nv_word(nv_idx_reg + 1'b1, count_reg, frozen_reg);
            end
          end
        end
        updown_event_counter_pkg::NV_DONE: begin
          if (!i_power_fail) begin
            nv_state_reg <= updown_event_counter_pkg::NV_IDLE;
          end
        end
        default: nv_state_reg <= updown_event_counter_pkg::NV_IDLE;
      endcase
    end
  end

  assign o_nv_valid = nv_state_reg == updown_event_counter_pkg::NV_SAVE;
  assign o_nv_done = nv_state_reg == updown_event_counter_pkg::NV_DONE;
  assign o_nv_addr = nv_idx_reg;

endmodule : updown_event_counter
